/* File: hw/glue_pkg.sv */
// shared constants for the controller board glue logic
package glue_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int NUM_SEL = 8;
    // io select numbers
    localparam logic [2:0] SEL_LED = 3'h3;
    localparam logic [2:0] SEL_ADC = 3'h4;
    localparam logic [2:0] SEL_PPI = 3'h5;
    localparam logic [2:0] SEL_SWITCH = 3'h6;
    localparam logic [2:0] SEL_LCD = 3'h7;
    // decode qualifier: a7 and a15 both high
    localparam int QUAL_LOW_BIT = 7;
    localparam int QUAL_HIGH_BIT = 15;
    localparam int SEL_FIELD_LSB = 4;
    localparam int RAM_ADDR_W = 15;
    localparam int ADC_CHAN_W = 3;
    localparam int LCD_ADDR_W = 2;
    // adc channel assignments
    localparam logic [2:0] ADC_CHAN_LED_CURRENT = 3'h0;
    localparam logic [2:0] ADC_CHAN_REFERENCE = 3'h7;
    // backlight timeouts
    localparam int BACKLIGHT_PRESS_S = 120;
    localparam int BACKLIGHT_DOOR_S = 30;
    localparam longint BACKLIGHT_PRESS_CYC = longint'(BACKLIGHT_PRESS_S) * CLK_HZ;
    localparam longint BACKLIGHT_DOOR_CYC = longint'(BACKLIGHT_DOOR_S) * CLK_HZ;
    // watchdog default, ms
    localparam int WATCHDOG_MS = 100;
    localparam longint WATCHDOG_CYC = longint'(WATCHDOG_MS) * (CLK_HZ / 1000);
    localparam int LED_DIGITS = 6;
    localparam int DIGIT_TENTHS = 0;
    localparam int DIGIT_UNITS = 1;
    localparam int DP_BIT = 7;
    localparam logic [7:0] SEG_RESET = 8'hFF;
endpackage : glue_pkg

/* File: hw/glue_timer.sv */
// retriggerable down-counter used by the backlight and watchdog
`timescale 1ns/100ps
module glue_timer #(
    parameter int WIDTH = 32
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    input wire logic i_cancel,
    output logic o_running,
    output logic o_expired
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            count <= '0;
            o_expired <= 1'b0;
        end else if (i_ce) begin
            o_expired <= 1'b0;
            if (i_load) begin
                count <= i_count;
            end else if (i_cancel) begin
                count <= '0;
            end else if (count != '0) begin
                count <= count - 1'b1;
                // one-cycle pulse on the last tick
                o_expired <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
            end
        end
    end

    assign o_running = (count != '0);
endmodule : glue_timer

/* File: hw/glue_led_latch.sv */
// segment and digit-enable latches for the multiplexed led display
`timescale 1ns/100ps
module glue_led_latch #(
    parameter int DIGITS = glue_pkg::LED_DIGITS
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_load,
    input wire logic [7:0] i_data,
    input wire logic [15:0] i_addr,
    output logic [7:0] o_segment_n,
    output logic [DIGITS-1:0] o_digit_enable,
    output logic o_decimal_point_drive_n,
    output logic o_battery_symbol_n
);
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_segment_n <= glue_pkg::SEG_RESET;
            o_digit_enable <= '0;
        end else if (i_ce && i_load) begin
            o_segment_n <= i_data;
            o_digit_enable <= i_addr[DIGITS-1:0];
        end
    end

    always_comb begin
        o_decimal_point_drive_n = !(!o_segment_n[glue_pkg::DP_BIT]
            && o_digit_enable[glue_pkg::DIGIT_TENTHS]);
        o_battery_symbol_n = !(!o_segment_n[glue_pkg::DP_BIT]
            && o_digit_enable[glue_pkg::DIGIT_UNITS]);
    end
endmodule : glue_led_latch

/* File: hw/cpu_board_glue_logic.sv */
// glue logic between the microcontroller bus and the controller board peripherals
`timescale 1ns/100ps
module cpu_board_glue_logic #(
    parameter longint WATCHDOG_CYC = glue_pkg::WATCHDOG_CYC,
    parameter longint BACKLIGHT_PRESS_CYC = glue_pkg::BACKLIGHT_PRESS_CYC,
    parameter longint BACKLIGHT_DOOR_CYC = glue_pkg::BACKLIGHT_DOOR_CYC,
    parameter int LED_DIGITS = glue_pkg::LED_DIGITS
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // processor side
    input wire logic [7:0] i_muxed_addr_data_lines,
    output logic [7:0] o_muxed_addr_data_lines,
    output logic o_muxed_addr_data_lines_oe,
    input wire logic [7:0] i_addr_high,
    input wire logic i_ale,
    input wire logic i_cpu_rd_n,
    input wire logic i_cpu_wr_n,
    input wire logic i_program_fetch_enable_n,
    input wire logic i_watchdog_trigger,
    input wire logic i_watchdog_clear,
    // system bus
    output logic [15:0] o_addr,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_bus_read_strobe_n,
    output logic o_bus_write_strobe_n,
    output logic [7:0] o_io_select_n,
    output logic [14:0] o_ram_addr,
    output logic o_ram_ce_n,
    output logic o_program_oe_n,
    output logic o_adc_oe_n,
    output logic [2:0] o_adc_channel,
    output logic o_switch_oe_n,
    output logic o_io_select_5_n,
    output logic o_lcd_select_n,
    output logic [1:0] o_lcd_addr,
    // panel
    input wire logic i_touchswitch_n,
    input wire logic i_door_locked,
    output logic o_backlight_enable,
    output logic [7:0] o_segment_n,
    output logic [LED_DIGITS-1:0] o_digit_enable,
    output logic o_decimal_point_drive_n,
    output logic o_battery_symbol_n,
    output logic o_fault_line_n
);
    // pin synchronisers, first stage read only by second
    logic [7:0] sync1_ad, sync2_ad, sync1_ah, sync2_ah;
    logic [6:0] sync1_ctl, sync2_ctl;
    logic [7:0] low_addr;
    logic ale_q, press_q, door_q, trig_q, clr_q;
    logic ale, rd_n, wr_n, program_fetch_enable_n, trig, clr, press, door;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            sync1_ad <= 8'h00;
            sync2_ad <= 8'h00;
            sync1_ah <= 8'h00;
            sync2_ah <= 8'h00;
            sync1_ctl <= 7'h07;
            sync2_ctl <= 7'h07;
        end else if (i_ce) begin
            sync1_ad <= i_muxed_addr_data_lines;
            sync2_ad <= sync1_ad;
            sync1_ah <= i_addr_high;
            sync2_ah <= sync1_ah;
            sync1_ctl <= {i_door_locked, !i_touchswitch_n, i_watchdog_clear,
                i_watchdog_trigger, i_program_fetch_enable_n, i_cpu_wr_n, i_cpu_rd_n} ^ 7'h00;
            sync2_ctl <= {sync1_ctl[6:4], sync1_ctl[3], sync1_ctl[2:0]};
        end
    end

    always_comb begin
        rd_n = sync2_ctl[0];
        wr_n = sync2_ctl[1];
        program_fetch_enable_n = sync2_ctl[2];
        trig = sync2_ctl[3];
        clr = sync2_ctl[4];
        press = sync2_ctl[5];
        door = sync2_ctl[6];
        ale = i_ale;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            low_addr <= 8'h00;
            ale_q <= 1'b0;
        end else if (i_ce) begin
            ale_q <= ale;
            if (ale_q) begin
                low_addr <= sync2_ad;
            end
        end
    end

    assign o_addr = {sync2_ah, low_addr};

    assign o_bus_read_strobe_n = rd_n;
    assign o_bus_write_strobe_n = wr_n;

    function automatic logic [7:0] decode_select(input logic [15:0] a);
        logic [7:0] sel;
        sel = 8'hFF;
        if (a[glue_pkg::QUAL_LOW_BIT] && a[glue_pkg::QUAL_HIGH_BIT]) begin
            sel[a[glue_pkg::SEL_FIELD_LSB +: 3]] = 1'b0;
        end
        return sel;
    endfunction : decode_select

    logic [7:0] sel_n;
    assign sel_n = decode_select(o_addr);
    assign o_io_select_n = sel_n;

    assign o_ram_addr = o_addr[glue_pkg::RAM_ADDR_W-1:0];
    assign o_ram_ce_n = !(!o_addr[glue_pkg::QUAL_HIGH_BIT] && (!rd_n || !wr_n));
    assign o_program_oe_n = program_fetch_enable_n;
    assign o_adc_oe_n = sel_n[glue_pkg::SEL_ADC] || rd_n;
    // channel from low address, fixes channel use
    assign o_adc_channel = o_addr[glue_pkg::ADC_CHAN_W-1:0];
    assign o_switch_oe_n = sel_n[glue_pkg::SEL_SWITCH] || rd_n;
    assign o_io_select_5_n = sel_n[glue_pkg::SEL_PPI];
    assign o_lcd_select_n = sel_n[glue_pkg::SEL_LCD];
    assign o_lcd_addr = o_addr[glue_pkg::LCD_ADDR_W-1:0];

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_data <= 8'h00;
            o_muxed_addr_data_lines <= 8'h00;
        end else if (i_ce) begin
            o_data <= sync2_ad;
            o_muxed_addr_data_lines <= i_data;
        end
    end
    assign o_data_oe = !wr_n && !ale;
    assign o_muxed_addr_data_lines_oe = (!rd_n || !program_fetch_enable_n) && !ale;

    // led latches loaded by select 3 and write
    glue_led_latch #(
        .DIGITS(LED_DIGITS)
    ) u_led (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_load(!sel_n[glue_pkg::SEL_LED] && !wr_n),
        .i_data(sync2_ad),
        .i_addr(o_addr),
        .o_segment_n(o_segment_n),
        .o_digit_enable(o_digit_enable),
        .o_decimal_point_drive_n(o_decimal_point_drive_n),
        .o_battery_symbol_n(o_battery_symbol_n)
    );

    // edge detects on synchronised levels
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            press_q <= 1'b0;
            door_q <= 1'b0;
            trig_q <= 1'b0;
            clr_q <= 1'b0;
        end else if (i_ce) begin
            press_q <= press;
            door_q <= door;
            trig_q <= trig;
            clr_q <= clr;
        end
    end

    logic press_rise, door_rise, trig_rise, clr_rise;
    assign press_rise = press && !press_q;
    assign door_rise = door && !door_q;
    assign trig_rise = trig && !trig_q;
    assign clr_rise = clr && !clr_q;

    // backlight timeouts; a press restarts the long one
    logic bl_running, bl_expired;
    logic [31:0] bl_load;
    assign bl_load = press_rise ? 32'(BACKLIGHT_PRESS_CYC) : 32'(BACKLIGHT_DOOR_CYC);
    glue_timer #(
        .WIDTH(32)
    ) u_backlight (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_load(press_rise || door_rise),
        .i_count(bl_load),
        .i_cancel(1'b0),
        .o_running(bl_running),
        .o_expired(bl_expired)
    );
    assign o_backlight_enable = bl_running;

    // watchdog one-shot; period is a parameter
    logic wd_running, wd_expired, fault;
    glue_timer #(
        .WIDTH(32)
    ) u_watchdog (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_load(trig_rise),
        .i_count(32'(WATCHDOG_CYC)),
        .i_cancel(1'b0),
        .o_running(wd_running),
        .o_expired(wd_expired)
    );

    // clear resets flip-flop; set wins on collision
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            fault <= 1'b0;
        end else if (i_ce) begin
            if (wd_expired) begin
                fault <= 1'b1;
            end else if (clr_rise) begin
                fault <= 1'b0;
            end
        end
    end
    assign o_fault_line_n = !fault;

    property p_wd_fault;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && wd_expired) |=> !o_fault_line_n;
    endproperty
    a_wd_fault: assert property (p_wd_fault) else $error("fault not raised");

    property p_wd_clear;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && clr_rise && !wd_expired) |=> o_fault_line_n;
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("fault not cleared");

    property p_one_select;
        @(posedge i_clk) disable iff (!i_nrst)
        $onehot0(~o_io_select_n);
    endproperty
    a_one_select: assert property (p_one_select) else $error("multiple selects");

    property p_adc_gate;
        @(posedge i_clk) disable iff (!i_nrst)
        !o_adc_oe_n |-> (!o_io_select_n[4] && !o_bus_read_strobe_n);
    endproperty
    a_adc_gate: assert property (p_adc_gate) else $error("adc gate");

    property p_sw_gate;
        @(posedge i_clk) disable iff (!i_nrst)
        !o_switch_oe_n |-> (!o_io_select_n[6] && !o_bus_read_strobe_n);
    endproperty
    a_sw_gate: assert property (p_sw_gate) else $error("switch gate");

    property p_bl_on;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && press_rise) |=> o_backlight_enable;
    endproperty
    a_bl_on: assert property (p_bl_on) else $error("backlight off after press");

    property p_prog;
        @(posedge i_clk) disable iff (!i_nrst)
        !o_program_oe_n |-> !program_fetch_enable_n;
    endproperty
    a_prog: assert property (p_prog) else $error("program oe without fetch");

    property p_addr;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && ale_q) |=> (o_addr[7:0] == $past(sync2_ad));
    endproperty
    a_addr: assert property (p_addr) else $error("low address not latched");
endmodule : cpu_board_glue_logic

/* File: sim/cpu_bus_model.sv */
// behavioural microcontroller that runs cycles on the multiplexed bus
`timescale 1ns/100ps
module cpu_bus_model (
    input wire logic i_clk,
    input wire logic [7:0] i_ad,
    output logic [7:0] o_ad,
    output logic [7:0] o_addr_high,
    output logic o_ale,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_program_fetch_enable_n
);
    logic [7:0] last;
    initial begin
        last = 8'h00;
        o_ad = 8'hFF;
        o_addr_high = 8'h00;
        o_ale = 1'b0;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_program_fetch_enable_n = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step
    task automatic start(input int kind, input logic [15:0] addr, input logic [7:0] data);
        step(1);
        o_ale = 1'b1;
        o_ad = addr[7:0];
        last = addr[7:0];
        o_addr_high = addr[15:8];
        step(3);
        o_ale = 1'b0;
        step(1);
        if (kind == 0) begin
            o_ad = data;
            last = data;
            o_wr_n = 1'b0;
        end else if (kind == 1) begin
            // released lines show the inverse, never a stale copy
            o_ad = ~last;
            o_rd_n = 1'b0;
        end else begin
            o_ad = ~last;
            o_program_fetch_enable_n = 1'b0;
        end
    endtask : start
    task automatic finish(output logic [7:0] rdata);
        rdata = i_ad;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_program_fetch_enable_n = 1'b1;
        step(1);
        o_ad = ~last;
        step(3);
    endtask : finish
endmodule : cpu_bus_model

/* File: sim/test_cpu_board_glue_logic.sv */
// self-checking bench for the controller board glue logic
`timescale 1ns/100ps
module test_cpu_board_glue_logic;
    logic i_clk, i_nrst, ale, rd_n, wr_n, program_fetch_enable_n, wd_trig, wd_clr, touch_n, door;
    logic [7:0] cpu_ad, addr_high, periph, mux_out, data_out, sel_n, seg_n, rdata;
    logic mux_oe, data_oe, brd_n, bwr_n, ram_ce_n, prog_oe_n, adc_oe_n, sw_oe_n, sel5_n;
    logic lcd_n, bl, dp_n, bat_n, fault_n;
    logic [15:0] addr, a;
    logic [14:0] ram_addr;
    logic [2:0] adc_ch;
    logic [1:0] lcd_a;
    logic [5:0] dig;
    wire [7:0] ad_bus = mux_oe ? mux_out : cpu_ad;
    wire [7:0] sys_data = data_oe ? data_out : periph;
    int error_cnt = 0;
    int n_checks = 0;
    integer seed = 78;
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    cpu_bus_model cpu_bus_model_inst (.i_clk(i_clk), .i_ad(ad_bus), .o_ad(cpu_ad),
        .o_addr_high(addr_high), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_program_fetch_enable_n(program_fetch_enable_n));
    cpu_board_glue_logic #(.WATCHDOG_CYC(50), .BACKLIGHT_PRESS_CYC(200),
        .BACKLIGHT_DOOR_CYC(50), .LED_DIGITS(6)) cpu_board_glue_logic_inst (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_muxed_addr_data_lines(ad_bus),
        .o_muxed_addr_data_lines(mux_out), .o_muxed_addr_data_lines_oe(mux_oe),
        .i_addr_high(addr_high), .i_ale(ale), .i_cpu_rd_n(rd_n), .i_cpu_wr_n(wr_n),
        .i_program_fetch_enable_n(program_fetch_enable_n), .i_watchdog_trigger(wd_trig),
        .i_watchdog_clear(wd_clr), .o_addr(addr), .i_data(sys_data), .o_data(data_out),
        .o_data_oe(data_oe), .o_bus_read_strobe_n(brd_n), .o_bus_write_strobe_n(bwr_n),
        .o_io_select_n(sel_n), .o_ram_addr(ram_addr), .o_ram_ce_n(ram_ce_n),
        .o_program_oe_n(prog_oe_n), .o_adc_oe_n(adc_oe_n), .o_adc_channel(adc_ch),
        .o_switch_oe_n(sw_oe_n), .o_io_select_5_n(sel5_n), .o_lcd_select_n(lcd_n),
        .o_lcd_addr(lcd_a), .i_touchswitch_n(touch_n), .i_door_locked(door),
        .o_backlight_enable(bl), .o_segment_n(seg_n), .o_digit_enable(dig),
        .o_decimal_point_drive_n(dp_n), .o_battery_symbol_n(bat_n), .o_fault_line_n(fault_n));
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // expected one-hot low select from the address
    function automatic logic [7:0] sel_exp(input logic [15:0] x);
        if (x[7] && x[15]) sel_exp = ~(8'h01 << x[6:4]);
        else sel_exp = 8'hFF;
    endfunction : sel_exp
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    // long run limit
    initial begin
        #(50 * 20000);
        error_cnt++;
        wrap_up();
    end
    // one read or fetch with full decode checks
    task automatic read_check(input int kind, input logic [15:0] x);
        logic [7:0] sel;
        sel = sel_exp(x);
        periph = 8'($random(seed));
        cpu_bus_model_inst.start(kind, x, 8'h00);
        step(5);
        chk("addr", x, addr);
        chk("sel", 16'(sel), 16'(sel_n));
        chk("adc_oe", 16'(sel[4] | (kind != 1)), 16'(adc_oe_n));
        chk("sw_oe", 16'(sel[6] | (kind != 1)), 16'(sw_oe_n));
        chk("sel5", 16'(sel[5]), 16'(sel5_n));
        chk("lcd", {13'h0000, sel[7], x[1:0]}, {13'h0000, lcd_n, lcd_a});
        chk("adc_ch", 16'(x[2:0]), 16'(adc_ch));
        chk("ram", {x[15] | (kind == 2), x[14:0]}, {ram_ce_n, ram_addr});
        chk("strb", 16'({kind != 1, kind != 2}), 16'({brd_n, prog_oe_n}));
        cpu_bus_model_inst.finish(rdata);
        chk("rdata", 16'(periph), 16'(rdata));
    endtask : read_check
    initial begin
        periph = 8'h00;
        wd_trig = 1'b0;
        wd_clr = 1'b0;
        touch_n = 1'b1;
        door = 1'b0;
        i_nrst = 1'b0;
        step(8);
        i_nrst = 1'b1;
        step(3);
        chk("reset", 16'h0FFF, {3'h0, bl, seg_n, fault_n, brd_n, bwr_n, 1'b1});
        $display("test reset done");
        for (int s = 0; s < 8; s++) begin
            a = 16'($random(seed));
            read_check(1, {1'b1, a[14:8], 1'b1, s[2:0], a[3:0]});
        end
        read_check(1, {1'b0, a[14:0]});
        read_check(2, {1'b1, a[14:0]});
        $display("test decode done");
        // digit tenths and units both tried, dp bit both ways
        for (int i = 0; i < 4; i++) begin
            a = {12'h80B, 2'($random(seed)), i[1:0]};
            periph = {i[0] & i[1], 7'($random(seed))};
            cpu_bus_model_inst.start(0, a, periph);
            step(5);
            chk("wdata", {7'h00, 1'b1, 1'b0, periph}, {7'h00, data_oe, bwr_n, data_out});
            cpu_bus_model_inst.finish(rdata);
            chk("seg", 16'(periph), 16'(seg_n));
            chk("dig", 16'(a[5:0]), 16'(dig));
            chk("dp", 16'({~(~periph[7] & a[0]), ~(~periph[7] & a[1])}), 16'({dp_n, bat_n}));
        end
        $display("test led done");
        for (int i = 0; i < 8; i++) begin
            wd_trig = 1'b1;
            wd_clr = 1'b1;
            step(3);
            wd_trig = 1'b0;
            wd_clr = 1'b0;
            step(27);
            chk("fault_kept", 16'h0001, 16'(fault_n));
        end
        step(10);
        chk("fault_early", 16'h0001, 16'(fault_n));
        step(40);
        chk("fault_set", 16'h0000, 16'(fault_n));
        step(20);
        chk("fault_hold", 16'h0000, 16'(fault_n));
        wd_clr = 1'b1;
        step(3);
        wd_clr = 1'b0;
        step(3);
        chk("fault_clr", 16'h0001, 16'(fault_n));
        $display("test watchdog done");
        touch_n = 1'b0;
        step(3);
        touch_n = 1'b1;
        step(5);
        chk("bl_on", 16'h0001, 16'(bl));
        step(180);
        chk("bl_press", 16'h0001, 16'(bl));
        step(30);
        chk("bl_off", 16'h0000, 16'(bl));
        door = 1'b1;
        step(5);
        chk("bl_door", 16'h0001, 16'(bl));
        step(35);
        chk("bl_door_kept", 16'h0001, 16'(bl));
        step(25);
        chk("bl_door_off", 16'h0000, 16'(bl));
        $display("test backlight done");
        wrap_up();
    end
endmodule : test_cpu_board_glue_logic
